//--- hw/lc_dl_pkg.sv
// Package: register map, field positions, timing and carrier types for the data-link stack
//
// Functional notes
// - Data service mode carries alarm, link in slot 24
// - Slot 24 byte is 10111YD0, Y alarm, D link
// - Loop-carrier superframe twelve frames, D4 terminal framing
// - Signal framing bits also carry 24-bit data word
// - Select bit plus source field pick port or stack
// - External source aligns to 000111000111, forces boundary
// - Word order: concentrator, spoilers, maintenance, alarm, switch
// - Line-switch codes as listed, idle is 1111
// - Five byte stack sent when select=1, field=x10
// - Bytes one, two bits 5..0 form framing sequence
// - Third byte bit 7 first; spoilers sent as written
// - Tx ready bit 5 set; writes go next interval
// - Status read clears tx ready bit 5
// - Unchanged stack is resent every interval
// - Rx ready bit 4 set on new captured word
// - Status read clears rx ready bit 4
// - Rx stack frozen, no flag, while alignment lost
// - D4 framing: terminal 101010, signal 001110, frame one first
package lc_dl_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] TX_STACK_BASE_OFS = 12'h000; // Five transmit stack bytes
  localparam logic [11:0] RX_STACK_BASE_OFS = 12'h005; // Five receive stack bytes
  localparam logic [11:0] SRC_SELECT_OFS    = 12'h00a; // dl_source_select_reg
  localparam logic [11:0] SRC_FIELD_OFS     = 12'h00b; // dl_source_field_reg
  localparam logic [11:0] STATUS_OFS        = 12'h00c; // stack_ready_status_reg
  localparam logic [11:0] MODE_CTRL_OFS     = 12'h00d; // Framing mode, alarm, irq enable
  localparam int          STACK_BYTES       = 5;       // Bytes in each stack
  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int SELECT_BIT   = 6;     // Stack select bit
  localparam int FIELD_LSB    = 5;     // Source field bits 7..5, x10 = bit5 x
  localparam int TX_READY_BIT = 5;     // Transmit stack ready
  localparam int RX_READY_BIT = 4;     // Receive stack ready
  localparam int RAI_BIT      = 2;     // Remote alarm request
  localparam int IRQ_EN_BIT   = 3;     // Interrupt enable
  localparam logic [7:0] CTRL_RESET = 8'h00; // Control registers after reset
  localparam logic [1:0] MODE_D4   = 2'h0; // Plain superframe
  localparam logic [1:0] MODE_DDS  = 2'h1; // digital_data_service_mode
  localparam logic [1:0] MODE_LOOP = 2'h2; // Loop-carrier superframe
  // ---------------------------------------------------------------
  // Framing constants
  // ---------------------------------------------------------------
  localparam logic [11:0] ALIGN_SEQ      = 12'h1c7;  // 000111000111
  localparam logic [5:0]  D4_FS_PATTERN  = 6'h0e;    // 0,0,1,1,1,0 first at MSB
  localparam int          SF_FRAMES      = 12;       // Frames per superframe
  localparam int          FRAME_TIME_US  = 125;      // One frame
  localparam int          INTERVAL_MS    = 9;        // Data-link interval
  localparam int          INTERVAL_FRAMES = INTERVAL_MS * 1000 / FRAME_TIME_US; // 72
  localparam int          FS_PER_INTERVAL = INTERVAL_FRAMES / 2; // 36
  localparam int          ALIGN_BITS     = 12;       // Sync part of the Fs interval
  localparam int          WORD_BITS      = 24;       // Data word length
  localparam logic [2:0]  SLOT24_HEAD    = 3'h5;     // Leading 101 of slot 24
  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [11:0] addr;  // Register offset
    logic        wr;    // Write strobe
    logic        rd;    // Read strobe
    logic [7:0]  wdata; // Write data
  } reg_req_type;
endpackage

//--- hw/loop_carrier_data_link_stack.sv
// Data-link stack for data service and loop-carrier superframe framing
`timescale 1ns/1ps
`default_nettype none
module loop_carrier_data_link_stack (
  input  wire logic                   sys_clk,              // 20 MHz framer clock
  input  wire logic                   rst,                  // Synchronous reset, high
  input  wire lc_dl_pkg::reg_req_type reg_req,              // Host register request
  output logic [7:0]                  reg_rdata,            // Read data, one cycle later
  input  wire logic                   fbit_slot,            // Tx framing bit time pulse
  output logic                        tx_fbit,              // Tx framing bit
  input  wire logic                   tx_ext_datalink_port, // External Fs stream
  input  wire logic                   ts24_slot,            // Tx slot 24 time pulse
  input  wire logic                   dds_dl_in,            // Tx 8 kbit/s link bit
  output logic [7:0]                  tx_ts24_byte,         // Tx slot 24 byte, bit 1 at MSB
  input  wire logic                   rx_fs_strobe,         // Rx signal framing bit valid
  input  wire logic                   rx_fs_bit,            // Rx signal framing bit
  input  wire logic                   superframe_align_lost, // Rx alignment lost
  input  wire logic                   rx_ts24_strobe,       // Rx slot 24 byte valid
  input  wire logic [7:0]             rx_ts24_byte,         // Rx slot 24 byte
  output logic                        rx_dds_dl,            // Rx link bit
  output logic                        rx_dds_alarm,         // Rx far-end alarm seen
  output logic                        irq                   // Interrupt request, high
);
  // ---------------------------------------------------------------
  // Register file state
  // ---------------------------------------------------------------
  logic [7:0]  tx_stack_reg [lc_dl_pkg::STACK_BYTES]; // Host transmit stack
  logic [7:0]  rx_stack_reg [lc_dl_pkg::STACK_BYTES]; // Captured receive stack
  logic [7:0]  select_reg;                            // dl_source_select_reg
  logic [7:0]  field_reg;                             // dl_source_field_reg
  logic [7:0]  mode_reg;                              // Mode, alarm, irq enable
  logic        tx_ready_reg;                          // Status bit 5
  logic        rx_ready_reg;                          // Status bit 4
  // ---------------------------------------------------------------
  // Framing state
  // ---------------------------------------------------------------
  logic [6:0]  frame_reg;      // Frame in the 72-frame interval
  logic [6:0]  frame_next;     // Following frame
  logic [35:0] tx_word_reg;    // Latched Fs interval, first bit at MSB
  logic [11:0] ext_shift_reg;  // Recent external bits
  logic [35:0] rx_shift_reg;   // Recent received Fs bits
  logic [5:0]  rx_count_reg;   // Fs bits since alignment sequence
  logic        rx_locked_reg;  // Alignment sequence seen
  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire [1:0] mode        = mode_reg[1:0];
  wire       loop_mode   = (mode == lc_dl_pkg::MODE_LOOP);
  wire       dds_mode    = (mode == lc_dl_pkg::MODE_DDS);
  // Stack source needs select=1 and field bits 7..5 = 0,1,x
  wire       stack_src   = select_reg[lc_dl_pkg::SELECT_BIT] &
                           field_reg[lc_dl_pkg::FIELD_LSB + 1] &
                           ~field_reg[lc_dl_pkg::FIELD_LSB + 2];
  wire       is_wr       = reg_req.wr;
  wire       is_rd       = reg_req.rd;
  wire [11:0] addr       = reg_req.addr;
  wire       tx_hit      = (addr < lc_dl_pkg::TX_STACK_BASE_OFS + 12'h005);
  wire       rx_hit      = (addr >= lc_dl_pkg::RX_STACK_BASE_OFS) &&
                           (addr < lc_dl_pkg::RX_STACK_BASE_OFS + 12'h005);
  wire [2:0] tx_idx      = 3'(addr - lc_dl_pkg::TX_STACK_BASE_OFS);
  wire [2:0] rx_idx      = 3'(addr - lc_dl_pkg::RX_STACK_BASE_OFS);
  wire       status_rd   = is_rd && (addr == lc_dl_pkg::STATUS_OFS);
  // Frame position inside the superframe, frame 1 is position 0
  wire [3:0] sf_pos      = 4'(frame_reg % 7'd12);
  wire       fs_frame    = sf_pos[0];            // Even frames carry Fs
  wire [5:0] fs_index    = frame_reg[6:1];       // Fs bit in the interval
  wire       interval_start = fbit_slot && (frame_reg == 7'h00);
  // Framing bit choice
  wire       ft_bit      = ~sf_pos[2] ^ ~sf_pos[1] ? ~sf_pos[1] : ~sf_pos[1]; // 1,0,1,0,1,0
  wire [2:0] fs_pair     = sf_pos[3:1];
  wire       d4_fs_bit   = lc_dl_pkg::D4_FS_PATTERN[3'h5 - fs_pair];
  wire       stack_fs    = tx_word_reg[6'd35 - fs_index];
  wire       loop_fs     = stack_src ? stack_fs : tx_ext_datalink_port;
  wire       fbit_value  = !fs_frame ? ft_bit : (loop_mode ? loop_fs : d4_fs_bit);
  // External alignment: sequence completes on the last sync Fs bit
  wire [11:0] ext_window = {ext_shift_reg[10:0], tx_ext_datalink_port};
  wire       ext_align   = loop_mode && !stack_src && fbit_slot && fs_frame &&
                           (ext_window == lc_dl_pkg::ALIGN_SEQ);
  // Stack bytes assembled in line order, spoilers as written
  wire [35:0] stack_word = {tx_stack_reg[0][5:0], tx_stack_reg[1][5:0],
                            tx_stack_reg[2], tx_stack_reg[3], tx_stack_reg[4]};
  // Receive side
  wire [35:0] rx_window  = {rx_shift_reg[34:0], rx_fs_bit};
  wire       rx_active   = loop_mode && rx_fs_strobe && !superframe_align_lost;
  wire       rx_sync_hit = rx_active && (rx_window[11:0] == lc_dl_pkg::ALIGN_SEQ);
  wire       rx_capture  = rx_active && rx_locked_reg &&
                           (rx_count_reg == 6'(lc_dl_pkg::WORD_BITS - 1));
  wire       tx_ready_set = interval_start && loop_mode && stack_src;
  // Read mux
  logic [7:0] rd_value;
  always_comb begin
    rd_value = 8'h00;
    if (tx_hit) begin
      rd_value = tx_stack_reg[tx_idx];
    end else if (rx_hit) begin
      rd_value = rx_stack_reg[rx_idx];
    end else if (addr == lc_dl_pkg::SRC_SELECT_OFS) begin
      rd_value = select_reg;
    end else if (addr == lc_dl_pkg::SRC_FIELD_OFS) begin
      rd_value = field_reg;
    end else if (addr == lc_dl_pkg::STATUS_OFS) begin
      rd_value = {2'h0, tx_ready_reg, rx_ready_reg, 4'h0};
    end else if (addr == lc_dl_pkg::MODE_CTRL_OFS) begin
      rd_value = mode_reg;
    end
  end
  // Next frame: forced boundary after the external sequence
  always_comb begin
    if (ext_align) begin
      frame_next = 7'd24;
    end else if (frame_reg == 7'(lc_dl_pkg::INTERVAL_FRAMES - 1)) begin
      frame_next = 7'h00;
    end else begin
      frame_next = frame_reg + 7'h01;
    end
  end
  // ---------------------------------------------------------------
  // Host registers; writes land in the live stack and reach the line
  // only at the next interval start
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < lc_dl_pkg::STACK_BYTES; i++) begin
        tx_stack_reg[i] <= lc_dl_pkg::CTRL_RESET;
      end
      select_reg <= lc_dl_pkg::CTRL_RESET;
      field_reg  <= lc_dl_pkg::CTRL_RESET;
      mode_reg   <= lc_dl_pkg::CTRL_RESET;
      reg_rdata  <= 8'h00;
    end else begin
      if (is_wr && tx_hit) begin
        tx_stack_reg[tx_idx] <= reg_req.wdata;
      end
      if (is_wr && addr == lc_dl_pkg::SRC_SELECT_OFS) begin
        select_reg <= reg_req.wdata;
      end
      if (is_wr && addr == lc_dl_pkg::SRC_FIELD_OFS) begin
        field_reg <= reg_req.wdata;
      end
      if (is_wr && addr == lc_dl_pkg::MODE_CTRL_OFS) begin
        mode_reg <= reg_req.wdata;
      end
      if (is_rd) begin
        reg_rdata <= rd_value;
      end
    end
  end
  // ---------------------------------------------------------------
  // Ready flags: a set in the same cycle as the clearing read wins
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_ready_reg <= 1'b0;
      rx_ready_reg <= 1'b0;
      irq          <= 1'b0;
    end else begin
      tx_ready_reg <= tx_ready_set | (tx_ready_reg & ~status_rd);
      rx_ready_reg <= rx_capture | (rx_ready_reg & ~status_rd);
      irq          <= mode_reg[lc_dl_pkg::IRQ_EN_BIT] &
                      ((tx_ready_set | (tx_ready_reg & ~status_rd)) |
                       (rx_capture | (rx_ready_reg & ~status_rd)));
    end
  end
  // ---------------------------------------------------------------
  // Transmit framing bits; stack resent unchanged unless rewritten
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frame_reg     <= 7'h00;
      tx_fbit       <= 1'b0;
      tx_word_reg   <= '0;
      ext_shift_reg <= 12'h000;
    end else if (fbit_slot) begin
      frame_reg <= frame_next;
      tx_fbit   <= fbit_value;
      if (frame_reg == 7'h00) begin
        tx_word_reg <= stack_word;
      end
      if (fs_frame) begin
        ext_shift_reg <= ext_window;
      end
    end
  end
  // ---------------------------------------------------------------
  // Slot 24 in data service mode; other modes send all ones
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_ts24_byte <= 8'hff;
      rx_dds_dl    <= 1'b0;
      rx_dds_alarm <= 1'b0;
    end else begin
      if (ts24_slot) begin
        tx_ts24_byte <= dds_mode ?
          {lc_dl_pkg::SLOT24_HEAD, 2'h3, ~mode_reg[lc_dl_pkg::RAI_BIT], dds_dl_in, 1'b0} :
          8'hff;
      end
      if (rx_ts24_strobe && dds_mode) begin
        rx_dds_dl    <= rx_ts24_byte[1];
        rx_dds_alarm <= ~rx_ts24_byte[2];
      end
    end
  end
  // ---------------------------------------------------------------
  // Receive stack capture, halted while alignment is lost
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_shift_reg  <= '0;
      rx_count_reg  <= 6'h00;
      rx_locked_reg <= 1'b0;
      for (int i = 0; i < lc_dl_pkg::STACK_BYTES; i++) begin
        rx_stack_reg[i] <= 8'h00;
      end
    end else if (rx_active) begin
      rx_shift_reg <= rx_window;
      if (rx_capture) begin
        rx_stack_reg[0] <= {2'h0, rx_window[35:30]};
        rx_stack_reg[1] <= {2'h0, rx_window[29:24]};
        rx_stack_reg[2] <= rx_window[23:16];
        rx_stack_reg[3] <= rx_window[15:8];
        rx_stack_reg[4] <= rx_window[7:0];
        rx_locked_reg   <= 1'b0;
      end else if (rx_sync_hit && !rx_locked_reg) begin
        rx_locked_reg <= 1'b1;
        rx_count_reg  <= 6'h00;
      end else if (rx_locked_reg) begin
        rx_count_reg <= rx_count_reg + 6'h01;
      end
    end
  end
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  tx_ready_sets_a: assert property (@(posedge sys_clk) disable iff (rst)
    tx_ready_set |=> tx_ready_reg) else $error("tx ready not set");
  tx_ready_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    status_rd && !tx_ready_set |=> !tx_ready_reg) else $error("tx ready not cleared");
  rx_ready_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    status_rd && !rx_capture |=> !rx_ready_reg) else $error("rx ready not cleared");
  rx_frozen_a: assert property (@(posedge sys_clk) disable iff (rst)
    superframe_align_lost |=> $stable(rx_stack_reg[2]) && !$rose(rx_ready_reg))
    else $error("rx stack moved while unaligned");
  slot24_form_a: assert property (@(posedge sys_clk) disable iff (rst)
    ts24_slot && dds_mode |=> tx_ts24_byte[7:3] == 5'h17 && tx_ts24_byte[0] == 1'b0)
    else $error("slot 24 pattern wrong");
  slot24_link_a: assert property (@(posedge sys_clk) disable iff (rst)
    ts24_slot && dds_mode |=> tx_ts24_byte[1] == $past(dds_dl_in))
    else $error("slot 24 link bit wrong");
  ext_force_a: assert property (@(posedge sys_clk) disable iff (rst)
    ext_align |=> frame_reg == 7'd24) else $error("boundary not forced");
  stack_first_a: assert property (@(posedge sys_clk) disable iff (rst)
    fbit_slot && loop_mode && stack_src && frame_reg == 7'd25 ##1 1'b1
    |-> tx_fbit == tx_word_reg[23]) else $error("first word bit wrong");
  terminal_bit_a: assert property (@(posedge sys_clk) disable iff (rst)
    fbit_slot && frame_reg == 7'h00 |=> tx_fbit) else $error("frame one terminal bit");
  irq_follow_a: assert property (@(posedge sys_clk) disable iff (rst)
    tx_ready_set && mode_reg[lc_dl_pkg::IRQ_EN_BIT] |=> irq) else $error("irq missing");
  cv_tx_ready: cover property (@(posedge sys_clk) disable iff (rst) tx_ready_set);
  cv_rx_capture: cover property (@(posedge sys_clk) disable iff (rst) rx_capture);
  cv_ext_align: cover property (@(posedge sys_clk) disable iff (rst) ext_align);
  cv_set_clear: cover property (@(posedge sys_clk) disable iff (rst) tx_ready_set && status_rd);
endmodule
`default_nettype wire

//--- verification/line_side_model.sv
// Line-side model: frame timing pulses, external link stream and receive framer feed
`timescale 1ns/1ps
`default_nettype none
module line_side_model (
  input  wire logic       sys_clk,        // Framer clock
  output var  logic       fbit_slot,      // Framing bit time pulse
  output var  logic       ext_dl,         // External link stream bit
  output var  logic       ts24_slot,      // Slot 24 time pulse
  output var  logic       dds_dl_in,      // Link bit for slot 24
  output var  logic       rx_fs_strobe,   // Received Fs bit valid
  output var  logic       rx_fs_bit,      // Received Fs bit
  output var  logic       align_lost,     // Receive alignment lost
  output var  logic       rx_ts24_strobe, // Received slot 24 valid
  output var  logic [7:0] rx_ts24_byte    // Received slot 24 byte
);
  // ---------------------------------------------------------------
  // Line events, each launched just after a falling edge
  // ---------------------------------------------------------------
  initial begin
    {fbit_slot, ext_dl, ts24_slot, dds_dl_in} = 4'h0;
    {rx_fs_strobe, rx_fs_bit, align_lost, rx_ts24_strobe} = 4'h0;
    rx_ts24_byte = 8'h00;
  end
  // After its sample the line shows the inverse, so a stale bit never passes
  task automatic frame(input logic b);
    @(negedge sys_clk);
    fbit_slot = 1'b1;
    ext_dl    = b;
    @(negedge sys_clk);
    fbit_slot = 1'b0;
    ext_dl    = ~b;
  endtask
  // Slot 24 in both directions at once
  task automatic slot24(input logic d, input logic [7:0] rx);
    @(negedge sys_clk);
    {ts24_slot, rx_ts24_strobe, dds_dl_in, rx_ts24_byte} = {2'b11, d, rx};
    @(negedge sys_clk);
    {ts24_slot, rx_ts24_strobe, dds_dl_in, rx_ts24_byte} = {2'b00, ~d, ~rx};
  endtask
  // One received Fs bit
  task automatic rx_fs(input logic b);
    @(negedge sys_clk);
    {rx_fs_strobe, rx_fs_bit} = {1'b1, b};
    @(negedge sys_clk);
    {rx_fs_strobe, rx_fs_bit} = {1'b0, ~b};
  endtask
  // Alignment state seen by the receive framer
  task automatic set_align(input logic v);
    @(negedge sys_clk);
    align_lost = v;
  endtask
endmodule
`default_nettype wire

//--- verification/loop_carrier_data_link_stack_tb.sv
// Testbench: register, framing, data service and stack scenarios for the data-link stack
`timescale 1ns/1ps
`default_nettype none
module loop_carrier_data_link_stack_tb;
  // ---------------------------------------------------------------
  // Signals and bookkeeping
  // ---------------------------------------------------------------
  localparam logic [5:0] D4_FS_SEQ = 6'h0e; // Signal bits 0,0,1,1,1,0
  logic                   sys_clk;      // 50 ns framer clock
  logic                   rst;          // Synchronous reset
  lc_dl_pkg::reg_req_type req;          // Host request
  logic [7:0]             reg_rdata;    // Read data
  logic                   tx_fbit;      // Sent framing bit
  logic [7:0]             tx_ts24_byte; // Sent slot 24 byte
  logic                   rx_dds_dl;    // Received link bit
  logic                   rx_dds_alarm; // Received far-end alarm
  logic                   irq;          // Interrupt request
  wire logic              fbit_slot, ext_dl, ts24_slot, dds_dl_in;
  wire logic              rx_fs_strobe, rx_fs_bit, align_lost, rx_ts24_strobe;
  wire logic [7:0]        rx_ts24_byte;
  int                     failures;     // Mismatches
  int                     n_tests;      // Comparisons
  int                     fcnt;         // Frame count the design should hold
  int                     s;            // External stream index
  logic                   b;            // Current external bit
  logic                   odd;          // Fs frame
  logic [39:0]            stk;          // Stack image last written
  logic [35:0]            wd;           // Word expected this interval

  loop_carrier_data_link_stack i_loop_carrier_data_link_stack (
    .sys_clk(sys_clk), .rst(rst), .reg_req(req), .reg_rdata(reg_rdata),
    .fbit_slot(fbit_slot), .tx_fbit(tx_fbit), .tx_ext_datalink_port(ext_dl),
    .ts24_slot(ts24_slot), .dds_dl_in(dds_dl_in), .tx_ts24_byte(tx_ts24_byte),
    .rx_fs_strobe(rx_fs_strobe), .rx_fs_bit(rx_fs_bit), .superframe_align_lost(align_lost),
    .rx_ts24_strobe(rx_ts24_strobe), .rx_ts24_byte(rx_ts24_byte), .rx_dds_dl(rx_dds_dl),
    .rx_dds_alarm(rx_dds_alarm), .irq(irq));
  line_side_model i_line_side_model (
    .sys_clk(sys_clk), .fbit_slot(fbit_slot), .ext_dl(ext_dl), .ts24_slot(ts24_slot),
    .dds_dl_in(dds_dl_in), .rx_fs_strobe(rx_fs_strobe), .rx_fs_bit(rx_fs_bit),
    .align_lost(align_lost), .rx_ts24_strobe(rx_ts24_strobe), .rx_ts24_byte(rx_ts24_byte));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge sys_clk);
    req = '0;
  endtask
  // Read data lands one cycle after the strobe
  task automatic rd_check(input string what, input logic [11:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge sys_clk);
    req = '0;
    check(what, exp, reg_rdata);
  endtask
  function automatic logic [35:0] word(input logic [39:0] v);
    return {v[37:32], v[29:24], v[23:0]};
  endfunction
  task automatic load_stack(input logic [39:0] v);
    stk = v;
    for (int i = 0; i < 5; i++) begin
      wr(lc_dl_pkg::TX_STACK_BASE_OFS + 12'(i), v[39-8*i -: 8]);
    end
  endtask
  // Terminal bits follow the frame count; Fs bits are checked only when asked
  task automatic run_frame(input logic fs, input logic ext, input logic chk);
    logic exp;
    exp = fcnt[0] ? fs : logic'((fcnt % 12) % 4 == 0);
    i_line_side_model.frame(ext);
    if (chk || !fcnt[0]) check("framing bit", {7'h00, exp}, {7'h00, tx_fbit});
    fcnt = (fcnt + 1) % 72;
  endtask
  // Fs bits of a received word, then time for the ready flag to settle
  task automatic rx_word(input logic [35:0] w);
    for (int i = 35; i >= 0; i--) begin
      i_line_side_model.rx_fs(w[i]);
    end
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Watchdog: a hang ends in the closing report
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    $display("mismatch watchdog expected done seen hang");
    test_done();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {failures, n_tests, fcnt, s} = '0;
    {b, stk, wd} = '0;
    req = '0;
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    check("slot 24 idle", 8'hff, tx_ts24_byte);
    rd_check("status reset", lc_dl_pkg::STATUS_OFS, 8'h00);
    wr(12'h0ff, 8'h5a);
    rd_check("unmapped", 12'h0ff, 8'h00);
    wr(lc_dl_pkg::RX_STACK_BASE_OFS, 8'h33);
    rd_check("rx stack read only", lc_dl_pkg::RX_STACK_BASE_OFS, 8'h00);
    // Plain and data service modes share the D4 framing
    for (int m = 0; m < 2; m++) begin
      wr(lc_dl_pkg::MODE_CTRL_OFS, 8'(m));
      repeat (12) run_frame(D4_FS_SEQ[5 - (fcnt % 12) / 2], 1'b0, 1'b1);
    end
    // Slot 24 sent with no alarm then with alarm, received with alarm then none
    i_line_side_model.slot24(1'b1, 8'hba);
    check("slot 24 byte", 8'hbe, tx_ts24_byte);
    check("rx link", 8'h01, {7'h00, rx_dds_dl});
    check("rx alarm", 8'h01, {7'h00, rx_dds_alarm});
    wr(lc_dl_pkg::MODE_CTRL_OFS, 8'h05);
    i_line_side_model.slot24(1'b0, 8'hbc);
    check("slot 24 byte", 8'hb8, tx_ts24_byte);
    check("rx link", 8'h00, {7'h00, rx_dds_dl});
    check("rx alarm", 8'h00, {7'h00, rx_dds_alarm});
    // Stack source: sync bytes, switch code 1110; source field bit 5 left set
    load_stack(40'h0707a5ab5d);
    wr(lc_dl_pkg::SRC_SELECT_OFS, 8'h40);
    wr(lc_dl_pkg::SRC_FIELD_OFS, 8'h60);
    wr(lc_dl_pkg::MODE_CTRL_OFS, 8'h0a);
    while (fcnt != 0) run_frame(1'b0, 1'b0, 1'b0);
    // Interval one is rewritten midway, interval three is left alone
    for (int iv = 0; iv < 3; iv++) begin
      for (int f = 0; f < 72; f++) begin
        if (f == 0) wd = word(stk);
        run_frame(wd[35 - f / 2], 1'b0, 1'b1);
        if (f == 0) begin
          check("irq tx ready", 8'h01, {7'h00, irq});
          rd_check("status tx ready", lc_dl_pkg::STATUS_OFS, 8'h20);
          rd_check("status cleared", lc_dl_pkg::STATUS_OFS, 8'h00);
        end
        if (iv == 0 && f == 40) load_stack(40'h070796ab5d);
      end
    end
    // Field 110 is not the stack source: no ready flag, external port instead
    wr(lc_dl_pkg::SRC_FIELD_OFS, 8'hc0);
    run_frame(1'b0, 1'b0, 1'b0);
    rd_check("status no stack", lc_dl_pkg::STATUS_OFS, 8'h00);
    while (fcnt != 10) run_frame(1'b0, 1'b0, 1'b0);
    // External stream opens with the sync run off the frame count
    wd = word(40'h0707a5ab5d);
    repeat (90) begin
      odd = fcnt[0];
      b = odd ? wd[35 - s % 36] : ~b;
      run_frame(b, b, 1'b1);
      if (odd) begin
        s++;
        if (s == 12) fcnt = 24;
      end
    end
    // Receive stack, then a word while alignment is lost, then a fresh one
    wr(lc_dl_pkg::SRC_SELECT_OFS, 8'h00);
    rd_check("status before rx", lc_dl_pkg::STATUS_OFS, 8'h00);
    rx_word({12'h1c7, 24'hc33c99});
    check("irq rx ready", 8'h01, {7'h00, irq});
    rd_check("status rx ready", lc_dl_pkg::STATUS_OFS, 8'h10);
    rd_check("status cleared", lc_dl_pkg::STATUS_OFS, 8'h00);
    stk = 40'h0707c33c99;
    for (int i = 0; i < 5; i++) begin
      rd_check("rx stack", lc_dl_pkg::RX_STACK_BASE_OFS + 12'(i), stk[39-8*i -: 8]);
    end
    i_line_side_model.set_align(1'b1);
    rx_word({12'h1c7, 24'h5a5a5a});
    rd_check("status lost", lc_dl_pkg::STATUS_OFS, 8'h00);
    rd_check("rx kept", lc_dl_pkg::RX_STACK_BASE_OFS + 12'h002, 8'hc3);
    i_line_side_model.set_align(1'b0);
    rx_word({12'h1c7, 24'h5a5a5a});
    rd_check("rx renewed", lc_dl_pkg::RX_STACK_BASE_OFS + 12'h002, 8'h5a);
    test_done();
  end
endmodule
`default_nettype wire
